// ---- rtcc_calendar.sv ----
`timescale 1ns/100ps
`default_nettype none
module rtcc_calendar (
  // clock
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic step,
  input wire logic load,
  input wire logic [2:0] load_idx,
  input wire logic [6:0] load_val,
  // state
  output logic [rtcc_pkg::NUM_FIELDS-1:0][6:0] field,
  output logic [rtcc_pkg::NUM_FIELDS-1:0] updated
);
  import rtcc_pkg::*;
  logic [NUM_FIELDS-1:0][6:0] next_field;
  logic [NUM_FIELDS-1:0] next_updated;
  // month length, february follows the two year lsbs
  function automatic logic [6:0] month_days(input logic [6:0] mon, input logic [6:0] yr);
    case (mon)
      MON_FEB: return (yr[1:0] == 2'b00) ? DAYS_FEB_LEAP : DAYS_FEB;
      MON_APR, MON_JUN, MON_SEP, MON_NOV: return DAYS_SHORT;
      default: return DAYS_LONG;
    endcase
  endfunction : month_days
  // ==========================================================
  // carry chain
  always_comb begin
    next_field = field;
    next_updated = '0;
    if (step) begin
      next_updated[F_SEC] = 1'b1;
      next_field[F_SEC] = field[F_SEC] + 7'h01;
      if (field[F_SEC] == MAX_SEC) begin // [RL3]
        next_field[F_SEC] = RST_ZERO;
        next_updated[F_MIN] = 1'b1;
        next_field[F_MIN] = field[F_MIN] + 7'h01;
        if (field[F_MIN] == MAX_MIN) begin // [RL3]
          next_field[F_MIN] = RST_ZERO;
          next_updated[F_HOUR] = 1'b1;
          next_field[F_HOUR] = field[F_HOUR] + 7'h01;
          if (field[F_HOUR] == MAX_HOUR) begin // [RL3]
            next_field[F_HOUR] = RST_ZERO;
            next_updated[F_DOM] = 1'b1;
            next_updated[F_DOW] = 1'b1;
            next_field[F_DOW] = (field[F_DOW] == MAX_DOW) ? RST_DAY : field[F_DOW] + 7'h01;
            next_field[F_DOM] = field[F_DOM] + 7'h01;
            if (field[F_DOM] == month_days(field[F_MONTH], field[F_YEAR])) begin // [RL5]
              next_field[F_DOM] = RST_DAY;
              next_updated[F_MONTH] = 1'b1;
              next_field[F_MONTH] = field[F_MONTH] + 7'h01;
              if (field[F_MONTH] == MAX_MONTH) begin
                next_field[F_MONTH] = RST_DAY;
                next_updated[F_YEAR] = 1'b1;
                // seven-bit year wraps after its last value
                next_field[F_YEAR] = field[F_YEAR] + 7'h01; // [RL4]
              end
            end
          end
        end
      end
    end
    if (load) begin
      next_field[load_idx] = load_val;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      field <= {RST_ZERO, RST_DAY, RST_DAY, RST_DAY, RST_ZERO, RST_ZERO, RST_ZERO};
      updated <= '0;
    end else begin
      field <= next_field;
      updated <= next_updated;
    end
  end
endmodule : rtcc_calendar
`default_nettype wire

// ---- rtcc_control.sv ----
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RL1 - time advances from a 32.768 kHz rate, not the bus clock
// RL2 - an alarm can raise the baseband wake output
// RL3 - tick interrupt possible whenever a time field rolls over its maximum
// RL4 - years run up to 2127
// RL5 - month lengths with leap years drive day-of-month rollover
// RL6 - power-up register write accepted only with key byte 0x43
// RL7 - wake output forced low on system reset fall when enabled
// RL8 - power request follows its bit only with both keys correct
// RL9 - clearing the write gate locks all slow writes until reset
// RL10 - alarm sets power request when alarm power-on is enabled
// RL11 - alarm and tick flags set by events, cleared on read
// RL12 - alarm enable raises interrupt; single fire clears that enable
// RL13 - tick enable raises interrupt; single fire clears that enable
// RL14 - per-field and sub-second enables select tick sources
// RL15 - each alarm field compares unless its ignore bit is set
// RL16 - all fields ignored means alarm every second
// RL17 - bit 15 shows a write still pending into the slow domain; the two key registers return key bit 15 there instead
// RL18 - no interrupts while either power key is wrong
// RL19 - alarm evaluated once per second update in the slow domain
module rtcc_control #(
  parameter int EIGHTH_COUNT = rtcc_pkg::SLOW_PER_EIGHTH
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET,
  // register bus
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // power control
  input wire logic SYSTEM_RESET_N,
  output logic PMIC_POWER_REQUEST,
  output logic BASEBAND_WAKE_OUTPUT,
  // interrupt
  output logic IRQ
);
  import rtcc_pkg::*;
  logic alarm_power_on, write_gate, power_request, wake_low_on_reset;
  logic alarm_irq_enable, tick_irq_enable, single_fire;
  logic [NUM_TICK_SRC-1:0] incr_en;
  logic [NUM_FIELDS-1:0] match_ignore, field_eq, updated;
  logic [NUM_FIELDS-1:0][6:0] alarm_setting, counter;
  logic [15:0] first_power_key, second_power_key, rd_value, wr_merged;
  logic [1:0] irq_flags, irq_status, irq_mask, events;
  logic pend, wp, stall, take, apply, keys_ok, sys_reset_q, sys_fall;
  logic [7:0] pend_addr;
  logic [15:0] pend_data;
  logic slow_en, eighth_en, quarter_en, half_en, second_en;
  logic alarm_match, alarm_hit, tick_hit, alarm_fire, tick_fire;
  logic [NUM_TICK_SRC-1:0] tick_src;

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return (a >= base) && (d[7:2] < 6'(NUM_FIELDS)) && (d[1:0] == 2'b00);
  endfunction : in_range

  function automatic logic [2:0] field_idx(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return d[4:2];
  endfunction : field_idx

  // registers behind the slow-domain write path
  function automatic logic is_slow(input logic [7:0] a);
    return (a == ADR_POWER_UP) || (a == ADR_INT_ENABLES) || (a == ADR_INCR_ENABLES) ||
      (a == ADR_FIELD_MASKS) || (a == ADR_FIRST_KEY) || (a == ADR_SECOND_KEY) ||
      in_range(a, ADR_TIME_BASE) || in_range(a, ADR_ALARM_BASE);
  endfunction : is_slow

  // ==========================================================
  // timebase and calendar
  rtcc_timebase #(
    .EIGHTH_COUNT(EIGHTH_COUNT)
  ) u_timebase ( // [RL1]
    .clk(REF_CLK),
    .reset(RESET),
    .slow_en(slow_en),
    .eighth_en(eighth_en),
    .quarter_en(quarter_en),
    .half_en(half_en),
    .second_en(second_en)
  );

  rtcc_calendar u_calendar (
    .clk(REF_CLK),
    .reset(RESET),
    .step(second_en),
    .load(apply && in_range(pend_addr, ADR_TIME_BASE)),
    .load_idx(field_idx(pend_addr, ADR_TIME_BASE)),
    .load_val(pend_data[6:0]),
    .field(counter),
    .updated(updated)
  );

  // ==========================================================
  // event detection
  assign keys_ok = (first_power_key == FIRST_POWER_KEY_OK) &&
    (second_power_key == SECOND_POWER_KEY_OK);
  always_comb begin
    for (int i = 0; i < NUM_FIELDS; i++) begin
      field_eq[i] = (counter[i] == alarm_setting[i]);
    end
  end
  assign alarm_match = &(match_ignore | field_eq); // [RL15] [RL16]
  assign alarm_hit = updated[F_SEC] && alarm_match && keys_ok; // [RL19] [RL18]
  assign tick_src = {eighth_en, quarter_en, half_en, updated}; // [RL14]
  assign tick_hit = |(tick_src & incr_en) && keys_ok; // [RL3] [RL18]
  assign alarm_fire = alarm_hit && alarm_irq_enable; // [RL12]
  assign tick_fire = tick_hit && tick_irq_enable; // [RL13]
  assign events = {tick_fire, alarm_fire};
  assign sys_fall = sys_reset_q && !SYSTEM_RESET_N;

  // ==========================================================
  // bus slave
  assign take = (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
  assign apply = slow_en && pend;
  // one slow write in flight; another one waits
  assign stall = AVS_WRITE && pend && is_slow(AVS_ADDRESS); // [RL17]
  assign wr_merged = {AVS_BYTEENABLE[1] ? AVS_WRITEDATA[15:8] : rd_value[15:8],
    AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : rd_value[7:0]};

  always_comb begin
    rd_value = 16'h0000;
    wp = pend && (pend_addr == AVS_ADDRESS);
    if (in_range(AVS_ADDRESS, ADR_TIME_BASE)) begin
      rd_value[6:0] = counter[field_idx(AVS_ADDRESS, ADR_TIME_BASE)];
      rd_value[BIT_WRITE_PENDING] = wp; // [RL17]
    end else if (in_range(AVS_ADDRESS, ADR_ALARM_BASE)) begin
      rd_value[6:0] = alarm_setting[field_idx(AVS_ADDRESS, ADR_ALARM_BASE)];
      rd_value[BIT_WRITE_PENDING] = wp;
    end else begin
      case (AVS_ADDRESS)
        ADR_POWER_UP: begin
          rd_value[BIT_ALARM_POWER_ON] = alarm_power_on;
          rd_value[BIT_WRITE_GATE] = write_gate;
          rd_value[BIT_POWER_REQ] = power_request;
          rd_value[BIT_WAKE_LOW] = wake_low_on_reset;
          rd_value[BIT_WRITE_PENDING] = wp;
        end
        ADR_INT_FLAGS: rd_value[1:0] = irq_flags;
        ADR_INT_ENABLES: begin
          rd_value[BIT_ALARM_EN] = alarm_irq_enable;
          rd_value[BIT_TICK_EN] = tick_irq_enable;
          rd_value[BIT_SINGLE_FIRE] = single_fire;
          rd_value[BIT_WRITE_PENDING] = wp;
        end
        ADR_INCR_ENABLES: begin
          rd_value[NUM_TICK_SRC-1:0] = incr_en;
          rd_value[BIT_WRITE_PENDING] = wp;
        end
        ADR_FIELD_MASKS: begin
          rd_value[NUM_FIELDS-1:0] = match_ignore;
          rd_value[BIT_WRITE_PENDING] = wp;
        end
        ADR_FIRST_KEY: rd_value = first_power_key;
        ADR_SECOND_KEY: rd_value = second_power_key;
        ADR_IRQ_STATUS: rd_value[1:0] = irq_status;
        ADR_IRQ_MASK: rd_value[1:0] = irq_mask;
        default: rd_value = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h00000000;
      pend <= 1'b0;
      pend_addr <= 8'h00;
      pend_data <= 16'h0000;
    end else begin
      if (apply) begin
        pend <= 1'b0;
      end
      if (take) begin
        AVS_WAITREQUEST <= 1'b1;
      end else if ((AVS_READ || AVS_WRITE) && !stall) begin
        AVS_WAITREQUEST <= 1'b0;
        AVS_READDATA <= AVS_READ ? {16'h0000, rd_value} : 32'h00000000;
      end
      // a closed gate drops the write but still answers it
      if (take && AVS_WRITE && write_gate && is_slow(AVS_ADDRESS)) begin // [RL9]
        pend <= 1'b1;
        pend_addr <= AVS_ADDRESS;
        pend_data <= wr_merged;
      end
    end
  end

  // ==========================================================
  // power-up control
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      alarm_power_on <= 1'b0;
      write_gate <= RST_WRITE_GATE;
      power_request <= 1'b0;
      wake_low_on_reset <= 1'b0;
    end else begin
      if (apply && pend_addr == ADR_POWER_UP &&
          pend_data[KEY_MSB:KEY_LSB] == POWER_REG_WRITE_KEY) begin // [RL6]
        alarm_power_on <= pend_data[BIT_ALARM_POWER_ON];
        write_gate <= pend_data[BIT_WRITE_GATE]; // [RL9]
        power_request <= pend_data[BIT_POWER_REQ];
        wake_low_on_reset <= pend_data[BIT_WAKE_LOW];
      end
      if (alarm_hit && alarm_power_on) begin
        power_request <= 1'b1; // [RL10]
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      PMIC_POWER_REQUEST <= 1'b0;
      BASEBAND_WAKE_OUTPUT <= 1'b0;
      sys_reset_q <= 1'b1;
    end else begin
      PMIC_POWER_REQUEST <= keys_ok && power_request; // [RL8]
      sys_reset_q <= SYSTEM_RESET_N;
      if (sys_fall && wake_low_on_reset) begin
        BASEBAND_WAKE_OUTPUT <= 1'b0; // [RL7]
      end else if (alarm_hit) begin
        BASEBAND_WAKE_OUTPUT <= 1'b1; // [RL2]
      end
    end
  end

  // ==========================================================
  // slow-domain configuration
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      alarm_irq_enable <= 1'b0;
      tick_irq_enable <= 1'b0;
      single_fire <= 1'b0;
      incr_en <= '0;
      match_ignore <= '0;
    end else begin
      if (apply && pend_addr == ADR_INT_ENABLES) begin
        alarm_irq_enable <= pend_data[BIT_ALARM_EN];
        tick_irq_enable <= pend_data[BIT_TICK_EN];
        single_fire <= pend_data[BIT_SINGLE_FIRE];
      end
      if (apply && pend_addr == ADR_INCR_ENABLES) begin
        incr_en <= pend_data[NUM_TICK_SRC-1:0];
      end
      if (apply && pend_addr == ADR_FIELD_MASKS) begin
        match_ignore <= pend_data[NUM_FIELDS-1:0];
      end
      if (alarm_fire && single_fire) begin
        alarm_irq_enable <= 1'b0; // [RL12]
      end
      if (tick_fire && single_fire) begin
        tick_irq_enable <= 1'b0; // [RL13]
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      alarm_setting <= '0;
      first_power_key <= 16'h0000;
      second_power_key <= 16'h0000;
    end else if (apply) begin
      if (in_range(pend_addr, ADR_ALARM_BASE)) begin
        alarm_setting[field_idx(pend_addr, ADR_ALARM_BASE)] <= pend_data[6:0];
      end
      if (pend_addr == ADR_FIRST_KEY) begin
        first_power_key <= pend_data;
      end
      if (pend_addr == ADR_SECOND_KEY) begin
        second_power_key <= pend_data;
      end
    end
  end

  // ==========================================================
  // flags and interrupt output
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      irq_flags <= 2'h0;
      irq_status <= 2'h0;
      irq_mask <= 2'h0;
      IRQ <= 1'b0;
    end else begin
      // only bits that were returned get cleared; new events win
      if (take && AVS_READ && AVS_ADDRESS == ADR_INT_FLAGS) begin
        irq_flags <= (irq_flags & ~AVS_READDATA[1:0]) | events; // [RL11]
      end else begin
        irq_flags <= irq_flags | events; // [RL11]
      end
      if (take && AVS_WRITE && AVS_ADDRESS == ADR_IRQ_STATUS && AVS_BYTEENABLE[0]) begin
        irq_status <= (irq_status & ~AVS_WRITEDATA[1:0]) | events;
      end else begin
        irq_status <= irq_status | events;
      end
      if (take && AVS_WRITE && AVS_ADDRESS == ADR_IRQ_MASK && AVS_BYTEENABLE[0]) begin
        irq_mask <= AVS_WRITEDATA[1:0];
      end
      IRQ <= |(irq_status & irq_mask) && keys_ok; // [RL18]
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  power_gate_a: // [RL8]
    assert property (!keys_ok |=> !PMIC_POWER_REQUEST)
    else $error("power request high with wrong keys");
  key_check_a: // [RL6]
    assert property ((apply && pend_addr == ADR_POWER_UP &&
      pend_data[KEY_MSB:KEY_LSB] != POWER_REG_WRITE_KEY) |=>
      $stable(write_gate) && $stable(alarm_power_on) && $stable(wake_low_on_reset))
    else $error("power-up write taken without key");
  wake_low_a: // [RL7]
    assert property ((sys_fall && wake_low_on_reset) |=> !BASEBAND_WAKE_OUTPUT)
    else $error("wake not forced low on reset fall");
  gate_hold_a: // [RL9]
    assert property (!write_gate |=> !write_gate)
    else $error("write gate reopened");
  alarm_power_a: // [RL10]
    assert property ((alarm_hit && alarm_power_on) |=> power_request ##1 PMIC_POWER_REQUEST)
    else $error("alarm did not request power");
  flag_clear_a: // [RL11]
    assert property ((take && AVS_READ && AVS_ADDRESS == ADR_INT_FLAGS &&
      AVS_READDATA[1:0] == irq_flags && events == 2'h0) |=> irq_flags == 2'h0)
    else $error("flags not cleared by read");
  single_alarm_a: // [RL12]
    assert property ((alarm_fire && single_fire) |=> !alarm_irq_enable && irq_flags[FLAG_ALARM])
    else $error("single fire alarm enable kept");
  single_tick_a: // [RL13]
    assert property ((tick_fire && single_fire) |=> !tick_irq_enable && irq_flags[FLAG_TICK])
    else $error("single fire tick enable kept");
  all_mask_a: // [RL16]
    assert property ((updated[F_SEC] && match_ignore == ALL_FIELDS_IGNORED && keys_ok) |->
      alarm_hit)
    else $error("full mask did not alarm");
  quiet_unkeyed_a: // [RL18]
    assert property ((!keys_ok && irq_flags == 2'h0) |=> irq_flags == 2'h0 ##1 !IRQ)
    else $error("interrupt with wrong keys");
  write_stall_a: // [RL17]
    assert property ((stall && AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
    else $error("second slow write not held off");
  bus_answer_a:
    assert property ((AVS_READ && AVS_WAITREQUEST) |-> ##[1:2] !AVS_WAITREQUEST)
    else $error("read not answered");

  alarm_seen_c: cover property (alarm_fire);
  tick_seen_c: cover property (tick_fire);
  stall_seen_c: cover property (stall ##[1:1000] !AVS_WAITREQUEST);
  flag_read_c: cover property (take && AVS_READ && AVS_ADDRESS == ADR_INT_FLAGS && irq_flags != 2'h0);
endmodule : rtcc_control
`default_nettype wire

// ---- rtcc_control_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module rtcc_control_tb_top;
  import rtcc_pkg::*;
  logic REF_CLK = 0, RESET = 1, AVS_READ = 0, AVS_WRITE = 0, drop = 0, PMIC, WAKE, IRQ, WREQ, SRN;
  logic [7:0] AVS_ADDRESS = 8'h00, ra;
  logic [31:0] AVS_WRITEDATA = 32'h0, RDATA;
  logic [15:0] q;
  int miscompares = 0, checked = 0, seed = 59;
  rtcc_control #(.EIGHTH_COUNT(2)) rtcc_control_i (.REF_CLK(REF_CLK), .RESET(RESET),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(RDATA),
    .AVS_WAITREQUEST(WREQ), .SYSTEM_RESET_N(SRN), .PMIC_POWER_REQUEST(PMIC),
    .BASEBAND_WAKE_OUTPUT(WAKE), .IRQ(IRQ));
  rtcc_pmic_model rtcc_pmic_model_i (.clk(REF_CLK), .power_req(PMIC), .drop(drop),
    .sys_rst_n(SRN), .powered());
  initial forever #12.5 REF_CLK = !REF_CLK;
  // ==========================================
  // checking and closing
  task automatic test_done();
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [15:0] pu(input logic apo, gate, req, low);
    return {8'h43, 4'h0, low, req, gate, apo};
  endfunction : pu
  // ==========================================
  // bus cycles
  task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge REF_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= {16'h0000, d};
    do begin
      @(posedge REF_CLK);
      n++;
    end while (WREQ !== 1'b0 && n < 3000);
    if (n >= 3000) begin miscompares++; test_done(); end
    q = RDATA[15:0];
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : bus
  task automatic wslow(input logic [7:0] a, input logic [15:0] d);
    int n;
    logic key;
    // key registers use all 16 bits: wait for the value, not the pending bit
    key = (a == ADR_FIRST_KEY) || (a == ADR_SECOND_KEY);
    bus(a, 1'b1, d);
    n = 0;
    do begin bus(a, 1'b0, 16'h0); n++; end
    while ((key ? q !== d : q[15] !== 1'b0) && n < 2000);
    if (n >= 2000) begin miscompares++; test_done(); end
  endtask : wslow
  task automatic wait_irq();
    int n;
    for (n = 0; n < 30000 && IRQ !== 1'b1; n++) @(posedge REF_CLK);
    if (n >= 30000) begin miscompares++; test_done(); end
  endtask : wait_irq
  // ==========================================
  // main sequence
  initial begin
    repeat (3) @(posedge REF_CLK);
    RESET <= 1'b0;
    bus(ADR_POWER_UP, 1'b0, 16'h0); chk("pu_reset", q, 16'h0002);
    bus(ADR_INT_ENABLES, 1'b0, 16'h0); chk("en_reset", q, 16'h0000);
    repeat (3) begin
      ra = 8'h80 | (8'($random(seed)) & 8'h3C);
      bus(ra, 1'b1, 16'($random(seed)));
      bus(ra, 1'b0, 16'h0); chk("unmapped", q, 16'h0000);
    end
    wslow(ADR_POWER_UP, pu(1'b1, 1'b1, 1'b1, 1'b0)); chk("pmic_nokey", {15'h0, PMIC}, 16'h0);
    wslow(ADR_FIRST_KEY, FIRST_POWER_KEY_OK);
    wslow(ADR_SECOND_KEY, SECOND_POWER_KEY_OK);
    chk("pmic_key", {15'h0, PMIC}, 16'h1);
    wslow(ADR_POWER_UP, 16'h000A); chk("pu_badkey", q, 16'h0007);
    wslow(ADR_POWER_UP, pu(1'b1, 1'b1, 1'b0, 1'b1)); chk("pmic_off", {15'h0, PMIC}, 16'h0);
    bus(ADR_IRQ_MASK, 1'b1, 16'h0003);
    wslow(ADR_FIELD_MASKS, 16'h007F);
    wslow(ADR_INT_ENABLES, 16'h0001);
    wait_irq();
    repeat (3) @(posedge REF_CLK);
    chk("alarm_pwr", {14'h0, WAKE, PMIC}, 16'h3);
    bus(ADR_INT_FLAGS, 1'b0, 16'h0); chk("alarm_flag", {15'h0, q[0]}, 16'h1);
    @(posedge REF_CLK) drop <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    drop <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    chk("wake_low", {15'h0, WAKE}, 16'h0);
    wslow(ADR_INT_ENABLES, 16'h0000);
    bus(ADR_IRQ_STATUS, 1'b1, 16'h0003);
    repeat (3) @(posedge REF_CLK);
    chk("irq_clear", {15'h0, IRQ}, 16'h0);
    wslow(ADR_INCR_ENABLES, 16'h0200);
    wslow(ADR_INT_ENABLES, 16'h0006);
    wait_irq();
    bus(ADR_INT_ENABLES, 1'b0, 16'h0); chk("single_fire", q, 16'h0004);
    bus(ADR_INT_FLAGS, 1'b0, 16'h0); chk("tick_flag", {15'h0, q[1]}, 16'h1);
    bus(ADR_INT_FLAGS, 1'b0, 16'h0); chk("flag_rc", {15'h0, q[1]}, 16'h0);
    // second slow write is held off while the first is pending
    bus(ADR_IRQ_STATUS, 1'b1, 16'h0003);
    bus(ADR_FIELD_MASKS, 1'b1, 16'h0000);
    wslow(ADR_FIELD_MASKS, 16'h007E); chk("mask_stall", q, 16'h007E);
    wslow(ADR_INCR_ENABLES, 16'h0008);
    wslow(ADR_INT_ENABLES, 16'h0007);
    // last second of a non-leap february, seconds loaded last
    wslow(ADR_TIME_BASE + 8'h18, 16'h0001);
    wslow(ADR_TIME_BASE + 8'h14, 16'h0002);
    wslow(ADR_TIME_BASE + 8'h0C, 16'h001C);
    wslow(ADR_TIME_BASE + 8'h08, 16'h0017);
    wslow(ADR_TIME_BASE + 8'h04, 16'h003B);
    wslow(ADR_TIME_BASE, 16'h003B);
    wait_irq();
    bus(ADR_INT_FLAGS, 1'b0, 16'h0); chk("roll_flags", q, 16'h0003);
    bus(ADR_TIME_BASE + 8'h0C, 1'b0, 16'h0); chk("roll_dom", q, 16'h0001);
    bus(ADR_TIME_BASE + 8'h14, 1'b0, 16'h0); chk("roll_month", q, 16'h0003);
    bus(ADR_TIME_BASE + 8'h08, 1'b0, 16'h0); chk("roll_hour", q, 16'h0000);
    wslow(ADR_POWER_UP, pu(1'b0, 1'b0, 1'b0, 1'b0));
    wslow(ADR_INT_ENABLES, 16'h0001); chk("gate_shut", q, 16'h0004);
    test_done();
  end
endmodule : rtcc_control_tb_top
`default_nettype wire

// ---- rtcc_pkg.sv ----
`default_nettype none
package rtcc_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] ADR_POWER_UP = 8'h00;
  localparam logic [7:0] ADR_INT_FLAGS = 8'h04;
  localparam logic [7:0] ADR_INT_ENABLES = 8'h08;
  localparam logic [7:0] ADR_INCR_ENABLES = 8'h0C;
  localparam logic [7:0] ADR_FIELD_MASKS = 8'h10;
  localparam logic [7:0] ADR_TIME_BASE = 8'h14;
  localparam logic [7:0] ADR_ALARM_BASE = 8'h30;
  localparam logic [7:0] ADR_FIRST_KEY = 8'h50;
  localparam logic [7:0] ADR_SECOND_KEY = 8'h54;
  localparam logic [7:0] ADR_IRQ_STATUS = 8'h70;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h74;
  // ==========================================================
  // field positions
  localparam int BIT_ALARM_POWER_ON = 0;
  localparam int BIT_WRITE_GATE = 1;
  localparam int BIT_POWER_REQ = 2;
  localparam int BIT_WAKE_LOW = 3;
  localparam int KEY_LSB = 8;
  localparam int KEY_MSB = 15;
  localparam int BIT_WRITE_PENDING = 15;
  localparam int BIT_ALARM_EN = 0;
  localparam int BIT_TICK_EN = 1;
  localparam int BIT_SINGLE_FIRE = 2;
  localparam int FLAG_ALARM = 0;
  localparam int FLAG_TICK = 1;
  localparam int NUM_FIELDS = 7;
  localparam int NUM_TICK_SRC = 10;
  localparam int F_SEC = 0;
  localparam int F_MIN = 1;
  localparam int F_HOUR = 2;
  localparam int F_DOM = 3;
  localparam int F_DOW = 4;
  localparam int F_MONTH = 5;
  localparam int F_YEAR = 6;
  // ==========================================================
  // values
  localparam logic [7:0] POWER_REG_WRITE_KEY = 8'h43;
  localparam logic [15:0] FIRST_POWER_KEY_OK = 16'hA357;
  localparam logic [15:0] SECOND_POWER_KEY_OK = 16'h67D2;
  localparam logic [6:0] ALL_FIELDS_IGNORED = 7'h7F;
  localparam logic [6:0] MAX_SEC = 7'h3B;
  localparam logic [6:0] MAX_MIN = 7'h3B;
  localparam logic [6:0] MAX_HOUR = 7'h17;
  localparam logic [6:0] MAX_DOW = 7'h07;
  localparam logic [6:0] MAX_MONTH = 7'h0C;
  localparam logic [6:0] MON_FEB = 7'h02;
  localparam logic [6:0] MON_APR = 7'h04;
  localparam logic [6:0] MON_JUN = 7'h06;
  localparam logic [6:0] MON_SEP = 7'h09;
  localparam logic [6:0] MON_NOV = 7'h0B;
  localparam logic [6:0] DAYS_LONG = 7'h1F;
  localparam logic [6:0] DAYS_SHORT = 7'h1E;
  localparam logic [6:0] DAYS_FEB = 7'h1C;
  localparam logic [6:0] DAYS_FEB_LEAP = 7'h1D;
  // ==========================================================
  // reset values
  localparam logic [6:0] RST_ZERO = 7'h00;
  localparam logic [6:0] RST_DAY = 7'h01;
  localparam logic RST_WRITE_GATE = 1'b1;
  // ==========================================================
  // timing
  localparam int REF_CLK_HZ = 40_000_000;
  localparam int SLOW_CLK_HZ = 32_768;
  localparam int PHASE_INC = SLOW_CLK_HZ / 8;
  localparam int PHASE_MOD = REF_CLK_HZ / 8;
  localparam int SLOW_PER_EIGHTH = SLOW_CLK_HZ / 8;
endpackage : rtcc_pkg
`default_nettype wire

// ---- rtcc_pmic_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// power chip side: follows the request, pulls system reset on command
module rtcc_pmic_model (
  // clock
  input wire logic clk,
  // control
  input wire logic power_req,
  input wire logic drop,
  output logic sys_rst_n,
  output logic powered
);
  // ==========================================
  // reset line and supply state
  always_ff @(posedge clk) begin
    sys_rst_n <= !drop;
    powered <= power_req;
  end
endmodule : rtcc_pmic_model
`default_nettype wire

// ---- rtcc_timebase.sv ----
`timescale 1ns/100ps
`default_nettype none
module rtcc_timebase #(
  parameter int PHASE_INC = rtcc_pkg::PHASE_INC,
  parameter int PHASE_MOD = rtcc_pkg::PHASE_MOD,
  parameter int EIGHTH_COUNT = rtcc_pkg::SLOW_PER_EIGHTH
) (
  // clock
  input wire logic clk,
  input wire logic reset,
  // pulses
  output logic slow_en,
  output logic eighth_en,
  output logic quarter_en,
  output logic half_en,
  output logic second_en
);
  import rtcc_pkg::*;
  localparam int PW = $clog2(PHASE_MOD);
  localparam int EW = $clog2(EIGHTH_COUNT + 1);
  logic [PW-1:0] phase;
  logic [PW:0] sum;
  logic [EW-1:0] cnt;
  logic [2:0] sub;
  assign sum = {1'b0, phase} + (PW+1)'(PHASE_INC);
  // ==========================================================
  // fractional divider: average rate of the slow clock
  always_ff @(posedge clk) begin
    if (reset) begin
      phase <= '0;
      slow_en <= 1'b0;
    end else if (sum >= (PW+1)'(PHASE_MOD)) begin
      phase <= PW'(sum - (PW+1)'(PHASE_MOD));
      slow_en <= 1'b1;
    end else begin
      phase <= PW'(sum);
      slow_en <= 1'b0;
    end
  end
  // ==========================================================
  // sub-second divider
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt <= '0;
      sub <= 3'h0;
      eighth_en <= 1'b0;
      quarter_en <= 1'b0;
      half_en <= 1'b0;
      second_en <= 1'b0;
    end else begin
      eighth_en <= 1'b0;
      quarter_en <= 1'b0;
      half_en <= 1'b0;
      second_en <= 1'b0;
      if (slow_en) begin
        if (cnt == EW'(EIGHTH_COUNT - 1)) begin
          cnt <= '0;
          sub <= sub + 3'h1;
          eighth_en <= 1'b1;
          quarter_en <= sub[0];
          half_en <= &sub[1:0];
          second_en <= &sub;
        end else begin
          cnt <= cnt + EW'(1);
        end
      end
    end
  end
endmodule : rtcc_timebase
`default_nettype wire
